// file: src/wld_detector.sv
// Wake frame detector core: registers, frame walker, wake packet and
// pattern match, status flags and wake indication.
// Assumes a byte stream on i_clk and a plain register port.
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "wld_regs.svh"
module wld_detector #(
  parameter int PAT_REGS = `WLD_PAT_REGS
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Register port
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [15:0]      o_rdata,
  // Receive stream
  input  wire logic [7:0]  i_rx_data,
  input  wire logic        i_rx_vld,
  input  wire logic        i_rx_dv,
  input  wire logic        i_rx_crc_bad,
  // Interrupt and indication
  input  wire logic        i_pol_irq,
  output logic             o_irq_bit1,
  output logic             o_wake_irq,
  output logic             o_wake
);
  import wld_pkg::*;

  localparam int PB = 2 * PAT_REGS;
  localparam int PIW = $clog2(PB + 1);

  if (PAT_REGS < 1 || PAT_REGS > 32) begin : g_bad_pat
    $error("PAT_REGS out of range");
  end

  typedef struct packed {
    logic [15:0]               cfg;
    logic                      src;
    logic                      sfd;
    logic                      crc;
    logic                      hack;
    logic                      patf;
    logic                      mpf;
    logic [2:0][15:0]          pm;
    logic [2:0][15:0]          pw;
    logic [PAT_REGS-1:0][15:0] pat;
    wld_fsm_e                  fsm;
    logic [2:0]                ffc;
    wld_mp_e                   mp;
    logic [2:0]                idx;
    logic [3:0]                copy;
    logic                      pwok;
    logic [PIW-1:0]            pidx;
    logic                      pok;
    logic                      lvl;
    logic [5:0]                cnt;
    logic                      wake;
    logic                      irq;
    logic [15:0]               rdata;
  } wld_state_s;

  wld_state_s q;
  wld_state_s d;
  wld_byte_if bif ();

  // ==========================================================
  // Helpers
  function automatic logic [7:0] pick(input logic [15:0] w,
                                      input logic hi);
    pick = hi ? w[15:8] : w[7:0];
  endfunction

  // Pulse width on i_clk, rounded up from reference cycles.
  function automatic logic [5:0] pulse_cyc(input logic [1:0] sel);
    int n;
    n = (`WLD_PULSE_BASE_REF << sel) * `WLD_CLK_MHZ;
    pulse_cyc = 6'((n + `WLD_REF_MHZ - 1) / `WLD_REF_MHZ);
  endfunction

  function automatic logic [PAT_REGS-1:0][15:0] pat_rst();
    pat_rst = '0;
    if (PAT_REGS > 1) pat_rst[1] = `WLD_PAT1_RST;
    if (PAT_REGS > 3) pat_rst[3] = `WLD_PAT3_RST;
  endfunction

  // ==========================================================
  // Reorder stage
  wld_reorder u_reorder (
    .i_clk     (i_clk),
    .i_rstn    (i_rstn),
    .i_mode    (wld_ord_e'(q.cfg[`WLD_CFG_ORD_HI:`WLD_CFG_ORD_LO])),
    .i_data    (i_rx_data),
    .i_vld     (i_rx_vld),
    .i_dv      (i_rx_dv),
    .i_crc_bad (i_rx_crc_bad),
    .bo        (bif.prod)
  );

  // ==========================================================
  // Decode and frame-level terms
  logic [15:0] pm_off;
  logic [15:0] pw_off;
  logic [15:0] pat_off;
  logic        en;
  logic [7:0]  sfd_byte;
  logic        rd_stat;
  logic        wr_cfg;
  logic        frame_end;
  logic        gate;
  logic        mp_ok;
  logic        pat_hit;
  logic        ev;

  assign pm_off = i_addr - `WLD_ADDR_PM;
  assign pw_off = i_addr - `WLD_ADDR_PW;
  assign pat_off = i_addr - `WLD_ADDR_PAT;
  assign en = q.cfg[`WLD_CFG_EN];
  assign sfd_byte = q.cfg[`WLD_CFG_SFDSEL] ? `WLD_SFD_ALT
                                            : `WLD_SFD_NORM;
  assign rd_stat = i_rd && i_addr == `WLD_ADDR_STAT;
  assign wr_cfg = i_wr && i_addr == `WLD_ADDR_CFG;
  assign frame_end = en && q.fsm == WLD_BODY && !bif.dv;
  assign gate = q.cfg[`WLD_CFG_CRCG] && bif.crc_bad;
  // A wake packet counts once the search is done and, with the
  // password check on, the password matched.
  assign mp_ok = q.mp == WLD_MP_DONE &&
                 (!q.cfg[`WLD_CFG_SECURE] || q.pwok);
  assign pat_hit = q.pok && 32'(q.pidx) == PB;
  assign ev = frame_end && !gate &&
              ((mp_ok && q.cfg[`WLD_CFG_MPEN]) ||
               (pat_hit && q.cfg[`WLD_CFG_PATEN]));

  // ==========================================================
  // Next state
  // Clears are applied before sets so a same-cycle event survives.
  always_comb begin
    logic [7:0] b;
    logic       ffb;
    b = bif.data;
    ffb = b == `WLD_SYNC;
    d = q;
    d.irq = 1'b0;
    d.rdata = 16'h0000;

    // Register reads; status flags other than the source bit clear on read.
    if (i_rd) begin
      if (i_addr == `WLD_ADDR_CFG) begin
        d.rdata = q.cfg;
      end else if (rd_stat) begin
        d.rdata[`WLD_ST_SRC] = q.src;
        d.rdata[`WLD_ST_SFD] = q.sfd;
        d.rdata[`WLD_ST_CRC] = q.crc;
        d.rdata[`WLD_ST_HACK] = q.hack;
        d.rdata[`WLD_ST_PAT] = q.patf;
        d.rdata[`WLD_ST_MP] = q.mpf;
        d.sfd = 1'b0;
        d.crc = 1'b0;
        d.hack = 1'b0;
        d.patf = 1'b0;
        d.mpf = 1'b0;
      end else if (pm_off < 16'h0003) begin
        d.rdata = q.pm[pm_off[1:0]];
      end else if (pw_off < 16'h0003) begin
        d.rdata = q.pw[pw_off[1:0]];
      end else if (32'(pat_off) < PAT_REGS) begin
        d.rdata = q.pat[pat_off[4:0]];
      end
    end

    // Register writes. The level clear bit never stores.
    if (i_wr) begin
      if (wr_cfg) begin
        d.cfg = i_wdata;
        d.cfg[`WLD_CFG_LCLR] = 1'b0;
        if (i_wdata[`WLD_CFG_LCLR]) begin
          d.lvl = 1'b0;
        end
        if (i_wdata[`WLD_CFG_EN] && !en) begin
          d.src = 1'b1;
        end
      end else if (i_addr == `WLD_ADDR_STAT) begin
        d.src = i_wdata[`WLD_ST_SRC];
      end else if (pm_off < 16'h0003) begin
        d.pm[pm_off[1:0]] = i_wdata;
      end else if (pw_off < 16'h0003) begin
        d.pw[pw_off[1:0]] = i_wdata;
      end else if (32'(pat_off) < PAT_REGS) begin
        d.pat[pat_off[4:0]] = i_wdata;
      end
    end

    // Frame walker.
    case (q.fsm)
      WLD_IDLE: begin
        if (en && bif.dv) begin
          d.fsm = WLD_PRE;
        end
      end
      WLD_PRE: begin
        if (!bif.dv) begin
          d.fsm = WLD_IDLE;
          d.sfd = 1'b1;
        end else if (bif.vld && b == sfd_byte) begin
          d.fsm = WLD_BODY;
          d.ffc = 3'd0;
          d.mp = WLD_MP_SYNC;
          d.idx = 3'd0;
          d.copy = 4'd0;
          d.pwok = 1'b1;
          d.pidx = '0;
          d.pok = 1'b1;
        end else if (bif.vld && b != `WLD_PRE_A && b != `WLD_PRE_B) begin
          d.fsm = WLD_DROP;
          d.sfd = 1'b1;
        end
      end
      WLD_BODY: begin
        if (!bif.dv) begin
          d.fsm = WLD_IDLE;
        end else if (bif.vld) begin
          // Pattern must match the leading bytes of the frame.
          if (32'(q.pidx) < PB) begin
            if (b == pick(q.pat[q.pidx[PIW-1:1]], q.pidx[0])) begin
              d.pidx = q.pidx + 1'b1;
            end else begin
              d.pok = 1'b0;
            end
          end
          // Wake packet search: sync run, then sixteen addresses.
          case (q.mp)
            WLD_MP_SYNC: begin
              if (q.ffc == 3'd6 && b == pick(q.pm[2], 1'b1)) begin
                d.mp = WLD_MP_ADDR;
                d.idx = 3'd1;
                d.copy = 4'd0;
              end else if (ffb) begin
                d.ffc = (q.ffc == 3'd6) ? 3'd6 : q.ffc + 3'd1;
              end else begin
                d.ffc = 3'd0;
              end
            end
            WLD_MP_ADDR: begin
              // Bytes 0-1 sit in the top match register, 4-5 in the bottom one.
              if (b != pick(q.pm[2'd2 - q.idx[2:1]], !q.idx[0])) begin
                d.mp = WLD_MP_SYNC;
                d.ffc = ffb ? 3'd1 : 3'd0;
              end else if (q.idx == 3'd5) begin
                d.idx = 3'd0;
                d.copy = q.copy + 4'd1;
                if (q.copy == 4'd15) begin
                  d.mp = q.cfg[`WLD_CFG_SECURE] ? WLD_MP_PASS : WLD_MP_DONE;
                end
              end else begin
                d.idx = q.idx + 3'd1;
              end
            end
            WLD_MP_PASS: begin
              if (b != pick(q.pw[q.idx[2:1]], q.idx[0])) begin
                d.pwok = 1'b0;
              end
              d.idx = q.idx + 3'd1;
              if (q.idx == 3'd5) begin
                d.mp = WLD_MP_DONE;
              end
            end
            WLD_MP_DONE: begin
              d.mp = WLD_MP_DONE;
            end
            default: d.mp = WLD_MP_SYNC;
          endcase
        end
      end
      WLD_DROP: begin
        if (!bif.dv) begin
          d.fsm = WLD_IDLE;
        end
      end
      default: d.fsm = WLD_IDLE;
    endcase
    if (!en) begin
      d.fsm = WLD_IDLE;
    end

    // End of frame: flags set here win over a read clear.
    if (frame_end) begin
      if (bif.crc_bad) begin
        d.crc = 1'b1;
      end
      if (!gate) begin
        if (mp_ok) begin
          d.mpf = 1'b1;
        end
        if (q.mp == WLD_MP_DONE && q.cfg[`WLD_CFG_SECURE] && !q.pwok) begin
          d.hack = 1'b1;
        end
        if (pat_hit) begin
          d.patf = 1'b1;
        end
      end
    end

    // Indication: level holds until cleared, pulse counts down.
    d.irq = ev;
    if (d.cnt != 6'd0) begin
      d.cnt = q.cnt - 6'd1;
    end
    if (ev) begin
      if (q.cfg[`WLD_CFG_LEVEL]) begin
        d.lvl = 1'b1;
      end else begin
        d.cnt = pulse_cyc(q.cfg[`WLD_CFG_PW_HI:`WLD_CFG_PW_LO]);
      end
    end
    d.wake = d.cfg[`WLD_CFG_LEVEL] ? d.lvl : (d.cnt != 6'd0);
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
      q.cfg <= `WLD_CFG_RST;
      q.pat <= pat_rst();
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign o_rdata = q.rdata;
  assign o_wake = q.wake;
  assign o_wake_irq = q.irq;
  assign o_irq_bit1 = q.src ? q.irq : i_pol_irq;

  // ==========================================================
  // Checks
  a_sfd_search: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (en && q.fsm == WLD_PRE && bif.dv && bif.vld && bif.data == sfd_byte)
      |=> q.fsm == WLD_BODY)
    else $error("delimiter not accepted");

  a_crc_gates: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (frame_end && bif.crc_bad && q.cfg[`WLD_CFG_CRCG]) |=> !o_wake_irq)
    else $error("bad frame gave indication");

  a_level_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (wr_cfg && i_wdata[`WLD_CFG_LCLR] && i_wdata[`WLD_CFG_LEVEL] && !ev)
      |=> !o_wake)
    else $error("level not cleared");

  a_pulse_short: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (ev && !q.cfg[`WLD_CFG_LEVEL] && q.cfg[10:9] == 2'b00 && !q.wake)
      |=> o_wake [*3] ##1 (!o_wake || $past(ev)))
    else $error("pulse width wrong");

  a_idle_off: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !en |=> q.fsm == WLD_IDLE)
    else $error("walker active while disabled");

  a_irq_route: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (q.src && q.irq) |-> o_irq_bit1)
    else $error("wake interrupt not routed");

  a_src_auto: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (wr_cfg && i_wdata[`WLD_CFG_EN] && !en) |=> q.src)
    else $error("source not set on enable");

  a_sfd_flag: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (en && q.fsm == WLD_PRE && !bif.dv) |=> q.sfd)
    else $error("delimiter error not latched");

  a_mp_flag: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (frame_end && !gate && mp_ok) |=> q.mpf ##1 (q.mpf || $past(rd_stat)))
    else $error("wake flag lost");

endmodule
`default_nettype wire

// file: src/wld_regs.svh
// Register offsets, field positions, reset values and timing counts of
// the wake frame detector. Definitions only; include by bare name.
`ifndef WLD_REGS_SVH
`define WLD_REGS_SVH

// ==========================================================
// Register offsets (word addresses on the plain port)
`define WLD_ADDR_CFG  16'h04a0
`define WLD_ADDR_STAT 16'h04a1
`define WLD_ADDR_PM   16'h04a2
`define WLD_ADDR_PW   16'h04a5
`define WLD_ADDR_PAT  16'h04a8
`define WLD_PAT_REGS  8

// ==========================================================
// Configuration fields
`define WLD_CFG_ORD_HI 15
`define WLD_CFG_ORD_LO 14
`define WLD_CFG_SFDSEL 13
`define WLD_CFG_CRCG   12
`define WLD_CFG_LCLR   11
`define WLD_CFG_PW_HI  10
`define WLD_CFG_PW_LO  9
`define WLD_CFG_LEVEL  8
`define WLD_CFG_EN     7
`define WLD_CFG_SECURE 5
`define WLD_CFG_PATEN  1
`define WLD_CFG_MPEN   0
`define WLD_CFG_RST    16'h1000

// ==========================================================
// Status fields
`define WLD_ST_SRC  12
`define WLD_ST_SFD  7
`define WLD_ST_CRC  6
`define WLD_ST_HACK 5
`define WLD_ST_PAT  1
`define WLD_ST_MP   0

// ==========================================================
// Frame constants and pattern reset words
`define WLD_SFD_NORM 8'hd5
`define WLD_SFD_ALT  8'h5d
`define WLD_PRE_A    8'h55
`define WLD_PRE_B    8'haa
`define WLD_SYNC     8'hff
`define WLD_PAT1_RST 16'h1010
`define WLD_PAT3_RST 16'h1000

// ==========================================================
// Pulse timing: base width in reference clock cycles.
`define WLD_PULSE_BASE_REF 8
`define WLD_REF_MHZ        125
`define WLD_CLK_MHZ        40

`endif

// file: src/wld_pkg.sv
// Types shared by the wake frame detector modules.
// Assumes wld_regs.svh is compiled alongside for the numbers.
package wld_pkg;

  // Frame state, Gray coded along idle, preamble, body.
  typedef enum logic [1:0] {
    WLD_IDLE = 2'b00,
    WLD_PRE  = 2'b01,
    WLD_BODY = 2'b11,
    WLD_DROP = 2'b10
  } wld_fsm_e;

  // Wake packet search phase.
  typedef enum logic [1:0] {
    WLD_MP_SYNC = 2'b00,
    WLD_MP_ADDR = 2'b01,
    WLD_MP_PASS = 2'b11,
    WLD_MP_DONE = 2'b10
  } wld_mp_e;

  // Reorder modes.
  typedef enum logic [1:0] {
    WLD_ORD_NORM = 2'b00,
    WLD_ORD_BREV = 2'b01,
    WLD_ORD_NSWP = 2'b10,
    WLD_ORD_NREV = 2'b11
  } wld_ord_e;

endpackage

// file: src/wld_byte_if.sv
// Reordered receive byte stream between the reorder stage and the
// detector core. Both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface wld_byte_if;
  logic [7:0] data;
  logic       vld;
  logic       dv;
  logic       crc_bad;
  modport prod (output data, vld, dv, crc_bad);
  modport cons (input data, vld, dv, crc_bad);
endinterface
`default_nettype wire

// file: src/wld_reorder.sv
// Receive byte reorder stage: one register stage that reorders bits.
// Assumes the raw stream comes from logic on i_clk.
`timescale 1ns/100ps
`default_nettype none
module wld_reorder (
  // Clock and reset
  input  wire logic           i_clk,
  input  wire logic           i_rstn,
  // Raw stream
  input  wire wld_pkg::wld_ord_e i_mode,
  input  wire logic [7:0]     i_data,
  input  wire logic           i_vld,
  input  wire logic           i_dv,
  input  wire logic           i_crc_bad,
  // Reordered stream
  wld_byte_if.prod            bo
);
  import wld_pkg::*;

  typedef struct packed {
    logic [7:0] data;
    logic       vld;
    logic       dv;
    logic       crc;
  } wld_ro_s;

  wld_ro_s q;
  wld_ro_s d;

  // ==========================================================
  // Reorder
  // One combinational reorder ahead of a flop keeps bytes aligned.
  always_comb begin
    d = q;
    d.vld = i_vld;
    d.dv = i_dv;
    d.crc = i_crc_bad;
    case (i_mode)
      WLD_ORD_NORM: d.data = i_data;
      WLD_ORD_BREV: d.data = {<<{i_data}};
      WLD_ORD_NSWP: d.data = {i_data[3:0], i_data[7:4]};
      WLD_ORD_NREV: d.data = {i_data[4], i_data[5], i_data[6], i_data[7],
                              i_data[0], i_data[1], i_data[2], i_data[3]};
      default:      d.data = i_data;
    endcase
  end

  // Register the stage.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bo.data = q.data;
  assign bo.vld = q.vld;
  assign bo.dv = q.dv;
  assign bo.crc_bad = q.crc;

  a_nibble_swap: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_vld && i_mode == WLD_ORD_NSWP) |=>
      (bo.data == {$past(i_data[3:0]), $past(i_data[7:4])}))
    else $error("nibble swap output wrong");

endmodule
`default_nettype wire

// file: test/wld_station.sv
// Far station model: sends receive frames byte by byte on the clock.
// Assumes the bench builds each frame with preamble and delimiter.
`timescale 1ns/100ps
`default_nettype none
module wld_station (
  // Clock
  input  wire logic      i_clk,
  // Receive stream toward the detector
  output var logic [7:0] o_data,
  output var logic       o_vld,
  output var logic       o_dv,
  output var logic       o_crc_bad
);
  // ==========================================================
  // Idle state
  initial begin
    o_data = 8'h00;
    o_vld = 1'h0;
    o_dv = 1'h0;
    o_crc_bad = 1'h0;
  end

  // ==========================================================
  // Frame sender
  // Idle data shows the inverse of the last byte, so a stale byte never
  // passes for a fresh one; the CRC verdict stands from the end of frame.
  task automatic send(input logic [7:0] f[$], input logic bad);
    foreach (f[k]) begin
      @(posedge i_clk);
      o_dv <= 1'h1;
      o_vld <= 1'h1;
      o_data <= f[k];
    end
    @(posedge i_clk);
    o_dv <= 1'h0;
    o_vld <= 1'h0;
    o_crc_bad <= bad;
    o_data <= ~f[f.size()-1];
  endtask
endmodule
`default_nettype wire

// file: test/tb.sv
// Testbench of the wake frame detector: register tasks, frame tests.
// Assumes the station model drives the receive stream.
`timescale 1ns/100ps
`default_nettype none
`include "wld_regs.svh"
module tb;
  // ==========================================================
  // Signals
  logic        i_clk = 1'h0;
  logic        i_rstn = 1'h0;
  logic [15:0] i_addr = 16'h0000;
  logic [15:0] i_wdata = 16'h0000;
  logic        i_wr = 1'h0;
  logic        i_rd = 1'h0;
  logic        i_pol_irq = 1'h0;
  logic [15:0] o_rdata;
  logic        o_irq_bit1;
  logic        o_wake_irq;
  logic        o_wake;
  logic [7:0]  rx_data;
  logic        rx_vld;
  logic        rx_dv;
  logic        rx_bad;
  int          err_total = 0;
  int          total_checks = 0;
  logic [1:0]  mode_g = 2'h0;
  logic [7:0]  sfd_g = 8'hd5;
  logic [7:0]  bq[$];
  logic [7:0]  mac[6] = '{8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
  int          wid[4] = '{3, 6, 11, 21};

  always #12.5 i_clk = ~i_clk;

  wld_detector wld_detector_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_data(rx_data), .i_rx_vld(rx_vld),
    .i_rx_dv(rx_dv), .i_rx_crc_bad(rx_bad), .i_pol_irq(i_pol_irq), .o_irq_bit1(o_irq_bit1),
    .o_wake_irq(o_wake_irq), .o_wake(o_wake));
  wld_station wld_station_i (.i_clk(i_clk), .o_data(rx_data), .o_vld(rx_vld), .o_dv(rx_dv),
    .o_crc_bad(rx_bad));

  // ==========================================================
  // Compare tasks
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task chkn(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: count %0d, expected %0d", $time, got, exp);
    end
  endtask

  // ==========================================================
  // Register port tasks
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'h1;
    @(posedge i_clk);
    i_wr <= 1'h0;
  endtask
  task rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'h1;
    @(posedge i_clk);
    i_rd <= 1'h0;
    @(negedge i_clk);
    chk(o_rdata, exp);
  endtask

  // ==========================================================
  // Frame helpers
  // Every reorder mode is its own inverse, so the raw byte is ord(wanted).
  function automatic logic [7:0] ord(input logic [7:0] b);
    case (mode_g)
      2'h1: return {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
      2'h2: return {b[3:0], b[7:4]};
      2'h3: return {b[4], b[5], b[6], b[7], b[0], b[1], b[2], b[3]};
      default: return b;
    endcase
  endfunction
  task mk_wake(input logic pw, input logic [7:0] p0);
    bq = {};
    repeat (6) bq.push_back(8'hff);
    repeat (16) for (int k = 0; k < 6; k++) bq.push_back(mac[k]);
    if (pw) for (int k = 0; k < 6; k++) bq.push_back(p0 + 8'(k));
  endtask
  // Sends bq and counts interrupt, bit one and indication cycles after it.
  task go(input logic bad, input int ei, input int ew);
    logic [7:0] f[$];
    int         ni;
    int         nb;
    int         nw;
    f = {ord(8'h55), ord(8'h55), ord(8'h55), ord(sfd_g)};
    foreach (bq[k]) f.push_back(ord(bq[k]));
    wld_station_i.send(f, bad);
    ni = 0;
    nb = 0;
    nw = 0;
    repeat (32) begin
      @(negedge i_clk);
      ni += (o_wake_irq === 1'h1);
      nb += (o_irq_bit1 === 1'h1);
      nw += (o_wake === 1'h1);
    end
    chkn(ni, ei);
    chkn(nb, ei);
    if (ew >= 0) chkn(nw, ew);
  endtask

  // ==========================================================
  // Verdict
  task results;
    if (err_total == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog: the tests need well under a tenth of this span.
  initial begin
    #1000000;
    err_total++;
    results;
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'h1;
    rd(`WLD_ADDR_CFG, 16'h1000);
    rd(`WLD_ADDR_STAT, 16'h0000);
    rd(`WLD_ADDR_PAT + 16'h1, 16'h1010);
    rd(`WLD_ADDR_PAT + 16'h3, 16'h1000);
    rd(16'h0400, 16'h0000);
    chk({15'h0, o_irq_bit1}, 16'h0000);
    wr(`WLD_ADDR_PM + 16'h2, 16'h0211);
    wr(`WLD_ADDR_PM + 16'h1, 16'h2233);
    wr(`WLD_ADDR_PM, 16'h4455);
    wr(`WLD_ADDR_PW, 16'ha1a0);
    wr(`WLD_ADDR_PW + 16'h1, 16'ha3a2);
    wr(`WLD_ADDR_PW + 16'h2, 16'ha5a4);
    for (int j = 0; j < 8; j++) wr(`WLD_ADDR_PAT + 16'(j), {8'h31 + 8'(2*j), 8'h30 + 8'(2*j)});
    rd(`WLD_ADDR_PM + 16'h1, 16'h2233);
    rd(`WLD_ADDR_PW + 16'h1, 16'ha3a2);
    // Each reorder mode with its own pulse width; odd modes use the alternate delimiter.
    for (int i = 0; i < 4; i++) begin
      mode_g = 2'(i);
      sfd_g = i[0] ? 8'h5d : 8'hd5;
      wr(`WLD_ADDR_CFG, 16'h1081 | (16'(i) << 14) | (16'(i & 1) << 13) | (16'(i) << 9));
      mk_wake(1'h0, 8'h00);
      go(1'h0, 1, wid[i]);
      rd(`WLD_ADDR_STAT, 16'h1001);
      rd(`WLD_ADDR_STAT, 16'h1000);
    end
    mode_g = 2'h0;
    sfd_g = 8'hd5;
    wr(`WLD_ADDR_CFG, 16'h1081);
    go(1'h1, 0, 0);
    rd(`WLD_ADDR_STAT, 16'h1040);
    wr(`WLD_ADDR_CFG, 16'h0081);
    go(1'h1, 1, 3);
    rd(`WLD_ADDR_STAT, 16'h1041);
    wr(`WLD_ADDR_CFG, 16'h1081);
    sfd_g = 8'h12;
    go(1'h0, 0, 0);
    rd(`WLD_ADDR_STAT, 16'h1080);
    // A frame that ends inside its preamble is a delimiter error too.
    sfd_g = 8'h55;
    bq = {};
    go(1'h0, 0, 0);
    rd(`WLD_ADDR_STAT, 16'h1080);
    sfd_g = 8'hd5;
    wr(`WLD_ADDR_CFG, 16'h10a1);
    mk_wake(1'h1, 8'ha0);
    go(1'h0, 1, 3);
    rd(`WLD_ADDR_STAT, 16'h1001);
    mk_wake(1'h1, 8'hb0);
    go(1'h0, 0, 0);
    rd(`WLD_ADDR_STAT, 16'h1020);
    wr(`WLD_ADDR_CFG, 16'h1082);
    bq = {};
    for (int k = 0; k < 20; k++) bq.push_back(k < 16 ? 8'h30 + 8'(k) : 8'h00);
    go(1'h0, 1, 3);
    rd(`WLD_ADDR_STAT, 16'h1002);
    mk_wake(1'h0, 8'h00);
    go(1'h0, 0, 0);
    rd(`WLD_ADDR_STAT, 16'h1001);
    // Level mode holds until the clear bit is written.
    wr(`WLD_ADDR_CFG, 16'h1181);
    go(1'h0, 1, -1);
    chk({15'h0, o_wake}, 16'h0001);
    rd(`WLD_ADDR_STAT, 16'h1001);
    wr(`WLD_ADDR_CFG, 16'h1981);
    @(negedge i_clk);
    chk({15'h0, o_wake}, 16'h0000);
    rd(`WLD_ADDR_CFG, 16'h1181);
    wr(`WLD_ADDR_CFG, 16'h1001);
    go(1'h0, 0, 0);
    rd(`WLD_ADDR_STAT, 16'h1000);
    // Source bit back to polarity: bit one must follow the polarity input.
    wr(`WLD_ADDR_STAT, 16'h0000);
    i_pol_irq <= 1'h1;
    rd(`WLD_ADDR_STAT, 16'h0000);
    chk({15'h0, o_irq_bit1}, 16'h0001);
    results;
  end
endmodule
`default_nettype wire
